// ### hw/ifd_pkg.sv
// Package with codes and constants of the input function dispatch block
package ifd_pkg;

  // ****************************************
  // Function codes
  // ****************************************
  localparam logic [4:0] IFD_FN_NONE = 5'h00;
  localparam logic [4:0] IFD_FN_SUB1 = 5'h01;
  localparam logic [4:0] IFD_FN_SUB2 = 5'h02;
  localparam logic [4:0] IFD_FN_SUB12 = 5'h03;
  localparam logic [4:0] IFD_FN_FRZ1 = 5'h04;
  localparam logic [4:0] IFD_FN_FRZ2 = 5'h05;
  localparam logic [4:0] IFD_FN_FRZ12 = 5'h06;
  localparam logic [4:0] IFD_FN_REL1 = 5'h07;
  localparam logic [4:0] IFD_FN_REL2 = 5'h08;
  localparam logic [4:0] IFD_FN_REL3 = 5'h09;
  localparam logic [4:0] IFD_FN_REL4 = 5'h0A;
  localparam logic [4:0] IFD_FN_RELALL = 5'h0B;
  localparam logic [4:0] IFD_FN_REMOTE = 5'h0C;
  localparam logic [4:0] IFD_FN_CYCLE = 5'h0D;
  localparam logic [4:0] IFD_FN_MINMAX = 5'h0E;
  localparam logic [4:0] IFD_FN_LOCK = 5'h0F;
  localparam logic [4:0] IFD_FN_THUMB = 5'h10;
  localparam logic [4:0] IFD_FN_SERIAL = 5'h11;
  localparam logic [4:0] IFD_FN_MAX = 5'h11;

  // ****************************************
  // Characteristic field and start-up mode
  // ****************************************
  localparam int IFD_CHR_TYPE_BIT = 2;
  localparam logic [1:0] IFD_CHR_LOW = 2'h0;
  localparam logic [1:0] IFD_CHR_HIGH = 2'h1;
  localparam logic [1:0] IFD_CHR_RISE = 2'h2;
  localparam logic [1:0] IFD_CHR_FALL = 2'h3;
  localparam logic [3:0] IFD_STARTUP_EXT = 4'hA;

  // ****************************************
  // Reset values, synchroniser depth and state encoding
  // ****************************************
  localparam logic [4:0] IFD_FN_RST = 5'h00;
  localparam logic [2:0] IFD_CHR_RST = 3'h0;
  localparam int IFD_SYNC_STAGES = 2;

  typedef enum logic [2:0] {
    IFD_ST_BOOT = 3'b001,
    IFD_ST_HOLD = 3'b010,
    IFD_ST_RUN = 3'b100
  } ifd_state_t;

endpackage

// ### hw/ifd_source.sv
// Synchroniser and level/edge evaluation for one command source
`timescale 1ns/1ns
module ifd_source
  import ifd_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Raw source and its characteristic
  input wire logic raw_in,
  input wire logic [1:0] mode,
  // Evaluated results
  output logic level_active,
  output logic edge_pulse
);

  // ****************************************
  // Two-stage synchroniser and history
  // ****************************************
  logic s1_q, s1_d;
  logic s2_q, s2_d;
  logic s3_q, s3_d;
  // Marks which stages already hold a real pin sample, so reset gives no false edge
  logic [2:0] fill_q, fill_d;

  always_comb begin
    s1_d = raw_in;
    s2_d = s1_q;
    s3_d = s2_q;
    fill_d = {fill_q[1:0], 1'b1};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      fill_q <= 3'h0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
      fill_q <= fill_d;
    end
  end

  // ****************************************
  // Level and edge evaluation
  // ****************************************
  always_comb begin
    level_active = 1'b0;
    edge_pulse = 1'b0;
    case (mode)
      IFD_CHR_LOW: level_active = fill_q[1] && !s2_q;
      IFD_CHR_HIGH: level_active = fill_q[1] && s2_q;
      IFD_CHR_RISE: edge_pulse = fill_q[2] && s2_q && !s3_q;
      IFD_CHR_FALL: edge_pulse = fill_q[2] && !s2_q && s3_q;
      default: level_active = 1'b0;
    endcase
  end

endmodule // ifd_source

// ### hw/ifd_dispatch.sv
// Function dispatch for front keys and external control inputs
`timescale 1ns/1ns
module ifd_dispatch
  import ifd_pkg::*;
#(
  parameter int FREQ_W = 24
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Front keys, high while pressed
  input wire logic [2:0] key_in,
  // Control input pins
  input wire logic [3:0] ctl_in,
  // Key function codes
  input wire logic [4:0] key1_function_code,
  input wire logic [4:0] key2_function_code,
  input wire logic [4:0] key3_function_code,
  // Control input settings
  input wire logic [2:0] ctl_in1_characteristic,
  input wire logic [4:0] ctl_in1_function_code,
  input wire logic [2:0] ctl_in2_characteristic,
  input wire logic [4:0] ctl_in2_function_code,
  input wire logic [2:0] ctl_in3_characteristic,
  input wire logic [4:0] ctl_in3_function_code,
  input wire logic [2:0] ctl_in4_characteristic,
  input wire logic [4:0] ctl_in4_function_code,
  // Encoder values and settings
  input wire logic [FREQ_W-1:0] enc1_freq,
  input wire logic [FREQ_W-1:0] enc2_freq,
  input wire logic [FREQ_W-1:0] enc1_set_value,
  input wire logic [FREQ_W-1:0] enc2_set_value,
  input wire logic [3:0] enc1_startup_delay_mode,
  input wire logic [3:0] enc2_startup_delay_mode,
  input wire logic enc1_standstill,
  input wire logic enc2_standstill,
  // Effective frequencies
  output logic [FREQ_W-1:0] enc1_freq_out,
  output logic [FREQ_W-1:0] enc2_freq_out,
  // Static functions and start-up restart pulses
  output logic enc1_substitute,
  output logic enc2_substitute,
  output logic enc1_freeze,
  output logic enc2_freeze,
  output logic enc1_suppress,
  output logic enc2_suppress,
  output logic startup_restart1,
  output logic startup_restart2,
  output logic keypad_lock,
  // Dynamic pulses
  output logic [3:0] latch_release,
  output logic display_cycle,
  output logic minmax_reset,
  output logic thumbwheel_read,
  output logic serial_start
);

  localparam int NSRC = 7;

  // ****************************************
  // Source evaluation
  // ****************************************
  logic [NSRC-1:0] raw_all;
  logic [NSRC-1:0] lvl;
  logic [NSRC-1:0] edg;
  logic [1:0] chr_mode [NSRC];
  logic [4:0] fn [NSRC];

  // Codes above 17 act as no function
  function automatic logic [4:0] fn_clip(input logic [4:0] code);
    fn_clip = (code > IFD_FN_MAX) ? IFD_FN_NONE : code;
  endfunction

  always_comb begin
    raw_all = {ctl_in, key_in};
    for (int i = 0; i < 3; i++) begin
      chr_mode[i] = IFD_CHR_HIGH;
    end
    chr_mode[3] = ctl_in1_characteristic[1:0];
    chr_mode[4] = ctl_in2_characteristic[1:0];
    chr_mode[5] = ctl_in3_characteristic[1:0];
    chr_mode[6] = {1'b0, ctl_in4_characteristic[0]};
    fn[0] = fn_clip(key1_function_code);
    fn[1] = fn_clip(key2_function_code);
    fn[2] = fn_clip(key3_function_code);
    fn[3] = fn_clip(ctl_in1_function_code);
    fn[4] = fn_clip(ctl_in2_function_code);
    fn[5] = fn_clip(ctl_in3_function_code);
    fn[6] = fn_clip(ctl_in4_function_code);
  end

  // Keys are level-active for static codes other than the lock code, and rising-edge for dynamic ones
  logic [2:0] key_edge;

  for (genvar g = 0; g < NSRC; g++) begin : g_src
    ifd_source u_src (
      .clk(clk),
      .rst_n(rst_n),
      .raw_in(raw_all[g]),
      .mode(chr_mode[g]),
      .level_active(lvl[g]),
      .edge_pulse(edg[g])
    );
  end

  ifd_source u_keyedge [2:0] (
    .clk(clk),
    .rst_n(rst_n),
    .raw_in(key_in),
    .mode(IFD_CHR_RISE),
    .level_active(),
    .edge_pulse(key_edge)
  );

  // ****************************************
  // Static and dynamic decode
  // ****************************************
  logic [NSRC-1:0] act;
  logic [NSRC-1:0] pulse;
  logic [NSRC-1:0] edge_all;
  logic [17:0] st_hit;
  logic [17:0] dy_hit;

  always_comb begin
    st_hit = '0;
    dy_hit = '0;
    // Key sources run level-high, so their own edge outputs stay low
    edge_all = {edg[NSRC-1:3], key_edge | edg[2:0]};
    for (int i = 0; i < NSRC; i++) begin
      act[i] = lvl[i];
      pulse[i] = edge_all[i];
      if (i == 6) begin
        pulse[i] = 1'b0;
      end
      if (act[i] && !(i < 3 && fn[i] == IFD_FN_LOCK)) begin
        st_hit[fn[i]] = 1'b1;
      end
      if (pulse[i]) begin
        dy_hit[fn[i]] = 1'b1;
      end
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  logic [FREQ_W-1:0] hold1_q, hold1_d, hold2_q, hold2_d;
  logic [FREQ_W-1:0] f1_q, f1_d, f2_q, f2_d;
  logic [8:0] stat_q, stat_d;
  logic [7:0] dyn_q, dyn_d;
  ifd_state_t st_q, st_d;
  logic stand1_q, stand1_d, stand2_q, stand2_d;
  logic sub1, sub2, frz1, frz2;

  always_comb begin
    sub1 = st_hit[IFD_FN_SUB1] || st_hit[IFD_FN_SUB12];
    sub2 = st_hit[IFD_FN_SUB2] || st_hit[IFD_FN_SUB12];
    frz1 = st_hit[IFD_FN_FRZ1] || st_hit[IFD_FN_FRZ12];
    frz2 = st_hit[IFD_FN_FRZ2] || st_hit[IFD_FN_FRZ12];
    hold1_d = frz1 ? hold1_q : enc1_freq;
    hold2_d = frz2 ? hold2_q : enc2_freq;
    f1_d = sub1 ? enc1_set_value : (frz1 ? hold1_q : enc1_freq);
    f2_d = sub2 ? enc2_set_value : (frz2 ? hold2_q : enc2_freq);
    stand1_d = enc1_standstill;
    stand2_d = enc2_standstill;
    st_d = st_q;
    case (st_q)
      IFD_ST_BOOT: st_d = IFD_ST_HOLD;
      IFD_ST_HOLD: st_d = IFD_ST_RUN;
      IFD_ST_RUN: st_d = IFD_ST_RUN;
      default: st_d = IFD_ST_BOOT;
    endcase
    stat_d[0] = sub1;
    stat_d[1] = sub2;
    stat_d[2] = frz1;
    stat_d[3] = frz2;
    stat_d[4] = st_hit[IFD_FN_REMOTE] && enc1_startup_delay_mode == IFD_STARTUP_EXT;
    stat_d[5] = st_hit[IFD_FN_REMOTE] && enc2_startup_delay_mode == IFD_STARTUP_EXT;
    stat_d[6] = (st_q == IFD_ST_BOOT) || (enc1_standstill && !stand1_q);
    stat_d[7] = (st_q == IFD_ST_BOOT) || (enc2_standstill && !stand2_q);
    stat_d[8] = st_hit[IFD_FN_LOCK];
    dyn_d[0] = dy_hit[IFD_FN_REL1] || dy_hit[IFD_FN_RELALL];
    dyn_d[1] = dy_hit[IFD_FN_REL2] || dy_hit[IFD_FN_RELALL];
    dyn_d[2] = dy_hit[IFD_FN_REL3] || dy_hit[IFD_FN_RELALL];
    dyn_d[3] = dy_hit[IFD_FN_REL4] || dy_hit[IFD_FN_RELALL];
    dyn_d[4] = dy_hit[IFD_FN_CYCLE];
    dyn_d[5] = dy_hit[IFD_FN_MINMAX];
    dyn_d[6] = dy_hit[IFD_FN_THUMB];
    dyn_d[7] = dy_hit[IFD_FN_SERIAL];
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold1_q <= '0;
      hold2_q <= '0;
      f1_q <= '0;
      f2_q <= '0;
      stat_q <= '0;
      dyn_q <= '0;
      st_q <= IFD_ST_BOOT;
      stand1_q <= 1'b0;
      stand2_q <= 1'b0;
    end else begin
      hold1_q <= hold1_d;
      hold2_q <= hold2_d;
      f1_q <= f1_d;
      f2_q <= f2_d;
      stat_q <= stat_d;
      dyn_q <= dyn_d;
      st_q <= st_d;
      stand1_q <= stand1_d;
      stand2_q <= stand2_d;
    end
  end

  always_comb begin
    enc1_freq_out = f1_q;
    enc2_freq_out = f2_q;
    enc1_substitute = stat_q[0];
    enc2_substitute = stat_q[1];
    enc1_freeze = stat_q[2];
    enc2_freeze = stat_q[3];
    enc1_suppress = stat_q[4];
    enc2_suppress = stat_q[5];
    startup_restart1 = stat_q[6];
    startup_restart2 = stat_q[7];
    keypad_lock = stat_q[8];
    latch_release = dyn_q[3:0];
    display_cycle = dyn_q[4];
    minmax_reset = dyn_q[5];
    thumbwheel_read = dyn_q[6];
    serial_start = dyn_q[7];
  end

endmodule // ifd_dispatch

// ### dv/ifd_switch_model.sv
// Model of the switched control inputs
`timescale 1ns/1ns
module ifd_switch_model (
  // Switch states and types
  input wire logic [3:0] sw_closed,
  input wire logic [3:0] sw_pnp,
  // Pins seen by the block
  output logic [3:0] ctl_in
);
  // Open sink pulled up, open source pulled down
  assign ctl_in = ~(sw_closed ^ sw_pnp);
endmodule // ifd_switch_model

// ### dv/ifd_dispatch_asserts.sv
// Checker of the input function dispatch block
`timescale 1ns/1ns
module ifd_dispatch_asserts
  import ifd_pkg::*;
#(
  parameter int FREQ_W = 24
) (
  // Clock, reset and pins
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] ctl_in,
  // Settings
  input wire logic [2:0] ctl_in1_characteristic,
  input wire logic [4:0] ctl_in1_function_code,
  input wire logic [4:0] ctl_in2_function_code,
  input wire logic [4:0] ctl_in3_function_code,
  input wire logic [4:0] ctl_in4_function_code,
  input wire logic [FREQ_W-1:0] enc1_freq,
  input wire logic [FREQ_W-1:0] enc1_set_value,
  input wire logic [3:0] enc1_startup_delay_mode,
  input wire logic enc1_standstill,
  // Outputs
  input wire logic [FREQ_W-1:0] enc1_freq_out,
  input wire logic enc1_substitute,
  input wire logic enc1_freeze,
  input wire logic enc1_suppress,
  input wire logic startup_restart1,
  input wire logic keypad_lock,
  input wire logic display_cycle
);
  // ******
  // Properties
  // ******
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_rise;
    $rose(ctl_in[0]) && ctl_in1_characteristic[1:0] == IFD_CHR_RISE &&
      ctl_in1_function_code == IFD_FN_CYCLE;
  endsequence
  sequence s_held;
    enc1_freeze && $past(enc1_freeze) && !enc1_substitute && !$past(enc1_substitute);
  endsequence
  cyc_edge_a: assert property (s_rise |-> ##[2:4] display_cycle)
    else $error("display cycle missing");
  pulse_one_a: assert property (display_cycle |=> !display_cycle)
    else $error("display cycle too long");
  restart_a: assert property ($rose(enc1_standstill) |-> ##[1:3] startup_restart1)
    else $error("restart missing");
  suppress_a: assert property (enc1_suppress |-> $past(enc1_startup_delay_mode) == IFD_STARTUP_EXT)
    else $error("suppress without external mode");
  subst_val_a: assert property (enc1_substitute && $past(enc1_substitute) |->
    enc1_freq_out == $past(enc1_set_value))
    else $error("substitute value wrong");
  freeze_hold_a: assert property (s_held |-> $stable(enc1_freq_out))
    else $error("frozen value moved");
  live_val_a: assert property (!enc1_substitute && !enc1_freeze && !$past(enc1_freeze) &&
    !$past(enc1_substitute) && $past(rst_n) |-> enc1_freq_out == $past(enc1_freq))
    else $error("live value wrong");
  lock_src_a: assert property (keypad_lock |-> ctl_in1_function_code == IFD_FN_LOCK ||
    ctl_in2_function_code == IFD_FN_LOCK || ctl_in3_function_code == IFD_FN_LOCK ||
    ctl_in4_function_code == IFD_FN_LOCK)
    else $error("lock without control source");
endmodule // ifd_dispatch_asserts
bind ifd_dispatch ifd_dispatch_asserts #(.FREQ_W(FREQ_W)) i_chk (
  .clk(clk), .rst_n(rst_n), .ctl_in(ctl_in), .ctl_in1_characteristic(ctl_in1_characteristic),
  .ctl_in1_function_code(ctl_in1_function_code), .ctl_in2_function_code(ctl_in2_function_code),
  .ctl_in3_function_code(ctl_in3_function_code), .ctl_in4_function_code(ctl_in4_function_code),
  .enc1_freq(enc1_freq), .enc1_set_value(enc1_set_value), .enc1_standstill(enc1_standstill),
  .enc1_startup_delay_mode(enc1_startup_delay_mode), .enc1_freq_out(enc1_freq_out),
  .enc1_substitute(enc1_substitute), .enc1_freeze(enc1_freeze), .enc1_suppress(enc1_suppress),
  .startup_restart1(startup_restart1), .keypad_lock(keypad_lock), .display_cycle(display_cycle));

// ### dv/tb_ifd_dispatch.sv
// Testbench of the input function dispatch block
`timescale 1ns/1ns
module tb_ifd_dispatch;
  import ifd_pkg::*;
  // ******
  // Stimulus and observation
  // ******
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] key_in = 3'h0;
  logic [3:0] sw = 4'h0;
  logic [4:0] kc [3] = '{default: 5'h00};
  logic [4:0] cc [4] = '{default: 5'h00};
  logic [2:0] ch [4] = '{default: 3'h0};
  logic [23:0] f1 = 24'h000123, f2 = 24'h000456, s1 = 24'h00ABCD, s2 = 24'h00BEEF;
  logic [3:0] m1 = 4'h0, m2 = 4'h0;
  logic ss1 = 1'b0, ss2 = 1'b0;
  wire [3:0] ctl_in, rel;
  wire [23:0] o1, o2;
  wire sub1, sub2, frz1, frz2, sup1, sup2, rs1, rs2, lock, dc, mm, tw, ser;
  wire [9:0] pls = {rs2, rs1, ser, tw, mm, dc, rel};
  int pc [10] = '{default: 0};
  int b [10] = '{default: 0};
  int err_count = 0, n_tests = 0;
  logic [4:0] dl [10] = '{5'h00, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0D, 5'h0E, 5'h10, 5'h11};
  logic [9:0] dm [10] = '{10'h000, 10'h001, 10'h002, 10'h004, 10'h008, 10'h00F, 10'h010,
    10'h020, 10'h040, 10'h080};

  always #50 clk = ~clk;
  always @(negedge clk) for (int j = 0; j < 10; j++) pc[j] += pls[j];

  ifd_switch_model i_sw (.sw_closed(sw), .sw_pnp({ch[3][2], ch[2][2], ch[1][2], ch[0][2]}),
    .ctl_in(ctl_in));
  ifd_dispatch i_dut (
    .clk(clk), .rst_n(rst_n), .key_in(key_in), .ctl_in(ctl_in),
    .key1_function_code(kc[0]), .key2_function_code(kc[1]), .key3_function_code(kc[2]),
    .ctl_in1_characteristic(ch[0]), .ctl_in1_function_code(cc[0]),
    .ctl_in2_characteristic(ch[1]), .ctl_in2_function_code(cc[1]),
    .ctl_in3_characteristic(ch[2]), .ctl_in3_function_code(cc[2]),
    .ctl_in4_characteristic(ch[3]), .ctl_in4_function_code(cc[3]),
    .enc1_freq(f1), .enc2_freq(f2), .enc1_set_value(s1), .enc2_set_value(s2),
    .enc1_startup_delay_mode(m1), .enc2_startup_delay_mode(m2),
    .enc1_standstill(ss1), .enc2_standstill(ss2), .enc1_freq_out(o1), .enc2_freq_out(o2),
    .enc1_substitute(sub1), .enc2_substitute(sub2), .enc1_freeze(frz1), .enc2_freeze(frz2),
    .enc1_suppress(sup1), .enc2_suppress(sup2), .startup_restart1(rs1), .startup_restart2(rs2),
    .keypad_lock(lock), .latch_release(rel), .display_cycle(dc), .minmax_reset(mm),
    .thumbwheel_read(tw), .serial_start(ser));

  // ******
  // Tasks
  // ******
  task automatic chk(string n, logic [31:0] g, logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic ctl(int i, logic v);
    cyc(1);
    sw[i] = v ~^ ch[i][2];
    cyc(5);
  endtask
  task automatic key(int i, logic v);
    cyc(1);
    key_in[i] = v;
    cyc(5);
  endtask
  task automatic cfg(int i, logic [2:0] c, logic [4:0] f);
    cc[i] = 5'h00;
    ch[i] = c;
    ctl(i, 1'b0);
    cc[i] = f;
    cyc(5);
  endtask
  task automatic pchk(logic [9:0] e);
    for (int j = 0; j < 10; j++) chk("pulse", pc[j] - b[j], e[j]);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    #1000000;
    err_count++;
    end_sim;
  end

  initial begin
    cyc(3);
    rst_n = 1'b1;
    cyc(4);
    pchk(10'h300);
    chk("idle", {sub1, sub2, frz1, frz2, sup1, sup2, lock}, 0);
    for (int i = 0; i < 10; i++) begin
      kc[0] = dl[i];
      b = pc;
      key(0, 1'b1);
      key(0, 1'b0);
      pchk(dm[i]);
    end
    for (int i = 0; i < 4; i++) begin
      cfg(i % 3, {i[1], 1'b1, i[0]}, IFD_FN_CYCLE);
      b = pc;
      ctl(i % 3, 1'b1);
      chk("rise", pc[4] - b[4], !i[0]);
      ctl(i % 3, 1'b0);
      chk("fall", pc[4] - b[4], 1);
    end
    cfg(3, 3'h2, IFD_FN_CYCLE);
    b = pc;
    ctl(3, 1'b1);
    ctl(3, 1'b0);
    chk("in4", pc[4] - b[4], 0);
    cfg(0, 3'h1, IFD_FN_NONE);
    for (int c = 1; c < 7; c++) begin
      cc[0] = c[4:0];
      ctl(0, 1'b1);
      chk("stat", {frz2, frz1, sub2, sub1}, c < 4 ? c : (c - 3) << 2);
      chk("f1", o1, (c < 4 && c[0]) ? s1 : f1);
      chk("f2", o2, (c < 4 && c[1]) ? s2 : f2);
      ctl(0, 1'b0);
      chk("stat", {frz2, frz1, sub2, sub1}, 0);
    end
    cfg(0, 3'h0, IFD_FN_SUB1);
    chk("low", sub1, 1);
    ctl(0, 1'b1);
    chk("low", sub1, 0);
    cfg(0, 3'h1, IFD_FN_FRZ1);
    ctl(0, 1'b1);
    f1 = 24'h000777;
    cyc(3);
    chk("frz", o1, 24'h000123);
    ctl(0, 1'b0);
    chk("live", o1, 24'h000777);
    m1 = IFD_STARTUP_EXT;
    kc[1] = IFD_FN_REMOTE;
    key(1, 1'b1);
    chk("sup", {sup2, sup1}, 2'h1);
    key(1, 1'b0);
    chk("sup", {sup2, sup1}, 0);
    kc[2] = IFD_FN_LOCK;
    key(2, 1'b1);
    chk("klock", lock, 0);
    cfg(3, 3'h1, IFD_FN_LOCK);
    ctl(3, 1'b1);
    chk("lock", lock, 1);
    cfg(1, 3'h1, IFD_FN_LOCK);
    ctl(1, 1'b1);
    ctl(3, 1'b0);
    chk("lock", lock, 1);
    ctl(1, 1'b0);
    chk("lock", lock, 0);
    b = pc;
    ss1 = 1'b1;
    ss2 = 1'b1;
    cyc(5);
    pchk(10'h300);
    end_sim;
  end
endmodule // tb_ifd_dispatch
